// ===== rtl/addr_compare.sv
// Purpose: Masked compare of a received address against the own address
// Assumes: Request comes from logic on the same clock
// Notes:   Result is registered one cycle after the request
`timescale 1ns/1ns
`default_nettype none
module addr_compare (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire addr_mask_pkg::cmp_cfg_s   cfg,
  input  wire logic [9:0]                rx_addr,
  input  wire logic                      rx_valid,
  output var  addr_mask_pkg::cmp_result_s result
);

  // ************************************************************
  // Per-bit mismatch terms
  // ************************************************************
  logic [9:0]                 miss10;    // Ten-bit mismatches
  logic [6:0]                 miss7;     // Seven-bit mismatches
  logic                       hit;       // Whole address matched
  addr_mask_pkg::cmp_result_s result_d;  // Next result

  for (genvar i = 0; i < addr_mask_pkg::ADDR_W; i++) begin : g_bit
    // Bit n against own bit n
    assign miss10[i] = !cfg.address_ignore_bits[i]
                       && (rx_addr[i] != cfg.own_addr[i]);
    if (i < addr_mask_pkg::SEVEN_W) begin : g_seven
      // Bit n+1 against own bit n
      assign miss7[i] = !cfg.address_ignore_bits[i]
                        && (rx_addr[i+1] != cfg.own_addr[i]);
    end
  end

  assign hit = cfg.ten_bit ? ~|miss10 : ~|miss7;

  // Next result
  always_comb begin
    result_d       = result;
    result_d.done  = rx_valid;
    if (rx_valid) begin
      result_d.match = hit;
      result_d.addr  = rx_addr;
    end
  end

  // Result register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= '0;
    end else begin
      result <= result_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ten_ignore: assert property (
    rx_valid && cfg.ten_bit && cfg.address_ignore_bits[0]
    && (((rx_addr ^ cfg.own_addr) & ~cfg.address_ignore_bits) == 10'h000)
    && (rx_addr[0] != cfg.own_addr[0])
    |=> result.done && result.match)
    else $error("masked bit blocked a ten-bit match");

  a_ten_require: assert property (
    rx_valid && cfg.ten_bit
    && (((rx_addr ^ cfg.own_addr) & ~cfg.address_ignore_bits) != 10'h000)
    |=> result.done && !result.match)
    else $error("unmasked ten-bit mismatch still matched");

  // Seven-bit reference built apart from the per-bit terms above
  logic exp7;  // Seven-bit compare expected to match
  assign exp7 = ((rx_addr[7:1] ^ cfg.own_addr[6:0])
                 & ~cfg.address_ignore_bits[6:0]) == 7'h00;

  a_seven_shift: assert property (
    rx_valid && !cfg.ten_bit
    |=> result.done && (result.match == $past(exp7)))
    else $error("seven-bit compare used wrong bit positions");

  a_match_exact: assert property (
    rx_valid && cfg.ten_bit && (rx_addr == cfg.own_addr)
    |=> result.match ##1 (result.match || $past(rx_valid)))
    else $error("equal address did not match");

endmodule
`default_nettype wire

// ===== rtl/i2c_slave_address_mask.sv
// Purpose: Register front end and match logic for slave address masking
// Assumes: AXI4-Lite master, one write and one read in flight at most
// Notes:   Received address arrives from the serial engine on aclk
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_address_mask (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // Write data channel
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Write response channel
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read address channel
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // Read data channel
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Address from the serial engine
  input  wire logic [9:0]  rx_addr,
  input  wire logic        rx_valid,
  // Match indication to the serial engine
  output logic             addr_match,
  output logic             addr_done
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [9:0]  mask_q,    mask_d;     // Address ignore bits
  logic [9:0]  own_q,     own_d;      // Own slave address
  logic        ten_q,     ten_d;      // Ten-bit mode
  logic        lmatch_q,  lmatch_d;   // Last compare matched
  logic [9:0]  laddr_q,   laddr_d;    // Last compared address

  // ************************************************************
  // Bus channel state
  // ************************************************************
  logic        awh_q,     awh_d;      // Write address held
  logic [11:0] awa_q,     awa_d;      // Held write address
  logic        wh_q,      wh_d;       // Write data held
  logic [31:0] wd_q,      wd_d;       // Held write data
  logic [3:0]  ws_q,      ws_d;       // Held write strobes
  logic        bv_q,      bv_d;       // Write answer pending
  logic [1:0]  br_q,      br_d;       // Write answer code
  logic        rv_q,      rv_d;       // Read answer pending
  logic [31:0] rd_q,      rd_d;       // Read data
  logic [1:0]  rr_q,      rr_d;       // Read answer code

  // ************************************************************
  // Comparator link
  // ************************************************************
  addr_mask_pkg::cmp_cfg_s    cfg;    // Settings to comparator
  addr_mask_pkg::cmp_result_s res;    // Result from comparator
  logic                       do_wr;  // Write commits this cycle
  logic                       ar_go;  // Read taken this cycle

  // Handshake outputs
  assign awready = !awh_q && !bv_q;
  assign wready  = !wh_q && !bv_q;
  assign arready = !rv_q;
  assign do_wr   = awh_q && wh_q && !bv_q;
  assign ar_go   = arvalid && arready;

  // Registered bus outputs
  assign bvalid = bv_q;
  assign bresp  = br_q;
  assign rvalid = rv_q;
  assign rdata  = rd_q;
  assign rresp  = rr_q;

  // Comparator settings from registers
  assign cfg.ten_bit             = ten_q;
  assign cfg.own_addr            = own_q;
  assign cfg.address_ignore_bits = mask_q;

  // Match outputs come straight from the comparator flops
  assign addr_match = res.match;
  assign addr_done  = res.done;

  // ************************************************************
  // Comparator
  // ************************************************************
  addr_compare u_cmp (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .cfg      (cfg),
    .rx_addr  (rx_addr),
    .rx_valid (rx_valid),
    .result   (res)
  );

  // ************************************************************
  // Write path
  // ************************************************************
  // Catch address and data in either order, then commit once
  always_comb begin
    awh_d  = awh_q;
    awa_d  = awa_q;
    wh_d   = wh_q;
    wd_d   = wd_q;
    ws_d   = ws_q;
    bv_d   = bv_q;
    br_d   = br_q;
    mask_d = mask_q;
    own_d  = own_q;
    ten_d  = ten_q;
    // Take address
    if (awvalid && awready) begin
      awh_d = 1'b1;
      awa_d = awaddr;
    end
    // Take data
    if (wvalid && wready) begin
      wh_d = 1'b1;
      wd_d = wdata;
      ws_d = wstrb;
    end
    // Commit and answer
    if (do_wr) begin
      awh_d = 1'b0;
      wh_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = addr_mask_pkg::RESP_OKAY;
      unique case (awa_q)
        addr_mask_pkg::OFS_MASK: begin
          if (ws_q[0]) begin
            mask_d[7:0] = wd_q[7:0];
          end
          if (ws_q[1]) begin
            mask_d[9:8] = wd_q[9:8];
          end
        end
        addr_mask_pkg::OFS_CONFIG: begin
          if (ws_q[0]) begin
            own_d[7:0] = wd_q[7:0];
          end
          if (ws_q[1]) begin
            own_d[9:8] = wd_q[9:8];
          end
          if (ws_q[2]) begin
            ten_d = wd_q[addr_mask_pkg::CFG_TEN_BIT];
          end
        end
        addr_mask_pkg::OFS_STATUS: begin
          // Read-only, write dropped
          br_d = addr_mask_pkg::RESP_OKAY;
        end
        default: begin
          // Unmapped address
          br_d = addr_mask_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Answer taken
    if (bv_q && bready) begin
      bv_d = 1'b0;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // Answer one cycle after the address is taken
  always_comb begin
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (ar_go) begin
      rv_d = 1'b1;
      rd_d = 32'h0000_0000;
      rr_d = addr_mask_pkg::RESP_OKAY;
      unique case (araddr)
        addr_mask_pkg::OFS_MASK: begin
          // Bits above 9 read as zero
          rd_d[9:0] = mask_q;
        end
        addr_mask_pkg::OFS_CONFIG: begin
          rd_d[9:0]                      = own_q;
          rd_d[addr_mask_pkg::CFG_TEN_BIT] = ten_q;
        end
        addr_mask_pkg::OFS_STATUS: begin
          rd_d[addr_mask_pkg::STAT_MATCH]       = lmatch_q;
          rd_d[addr_mask_pkg::STAT_ADDR_LSB+:10] = laddr_q;
        end
        default: begin
          rr_d = addr_mask_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rv_q && rready) begin
      rv_d = 1'b0;
    end
  end

  // ************************************************************
  // Status capture
  // ************************************************************
  // Keep the last compare for software
  always_comb begin
    lmatch_d = lmatch_q;
    laddr_d  = laddr_q;
    if (res.done) begin
      lmatch_d = res.match;
      laddr_d  = res.addr;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // All state, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q   <= addr_mask_pkg::MASK_RESET;
      own_q    <= addr_mask_pkg::OWN_RESET;
      ten_q    <= addr_mask_pkg::TEN_BIT_RESET;
      lmatch_q <= 1'b0;
      laddr_q  <= 10'h000;
      awh_q    <= 1'b0;
      awa_q    <= 12'h000;
      wh_q     <= 1'b0;
      wd_q     <= 32'h0000_0000;
      ws_q     <= 4'h0;
      bv_q     <= 1'b0;
      br_q     <= addr_mask_pkg::RESP_OKAY;
      rv_q     <= 1'b0;
      rd_q     <= 32'h0000_0000;
      rr_q     <= addr_mask_pkg::RESP_OKAY;
    end else begin
      mask_q   <= mask_d;
      own_q    <= own_d;
      ten_q    <= ten_d;
      lmatch_q <= lmatch_d;
      laddr_q  <= laddr_d;
      awh_q    <= awh_d;
      awa_q    <= awa_d;
      wh_q     <= wh_d;
      wd_q     <= wd_d;
      ws_q     <= ws_d;
      bv_q     <= bv_d;
      br_q     <= br_d;
      rv_q     <= rv_d;
      rd_q     <= rd_d;
      rr_q     <= rr_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Read of the mask register being taken
  sequence s_mask_read;
    arvalid && arready && (araddr == addr_mask_pkg::OFS_MASK);
  endsequence

  // Full write to the mask register committing
  sequence s_mask_write;
    do_wr && (awa_q == addr_mask_pkg::OFS_MASK) && (ws_q[1:0] == 2'h3);
  endsequence

  a_mask_read_zero: assert property (
    s_mask_read |=> rvalid && (rdata[31:10] == 22'h000000)
    && (rdata[9:0] == $past(mask_q)))
    else $error("mask read showed bits above 9 or wrong value");

  a_mask_write_keep: assert property (
    s_mask_write |=> (mask_q == $past(wd_q[9:0])) && bvalid
    && (bresp == addr_mask_pkg::RESP_OKAY))
    else $error("mask write not stored in bits 9..0");

  a_status_follow: assert property (
    res.done |=> (lmatch_q == $past(res.match))
    && (laddr_q == $past(res.addr)))
    else $error("status did not capture the compare");

  a_match_latency: assert property (
    rx_valid |=> addr_done ##1 (addr_done == $past(rx_valid)))
    else $error("compare result not one cycle after request");

endmodule
`default_nettype wire

// ===== shared/addr_mask_pkg.sv
// Purpose: Shared constants and carriers for the slave address mask block
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes:   Offsets are byte addresses of aligned words
package addr_mask_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int          AXI_ADDR_W     = 12;       // Bus address width
  localparam logic [11:0] OFS_MASK       = 12'h000;  // Mask register
  localparam logic [11:0] OFS_CONFIG     = 12'h004;  // Own address, mode
  localparam logic [11:0] OFS_STATUS     = 12'h008;  // Last compare

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int          ADDR_W         = 10;       // Address width
  localparam int          SEVEN_W        = 7;        // Short address width
  localparam logic [9:0]  MASK_RESET     = 10'h000;  // Mask after reset
  localparam logic [9:0]  OWN_RESET      = 10'h000;  // Own address reset
  localparam logic        TEN_BIT_RESET  = 1'b0;     // Seven-bit at reset
  localparam int          CFG_TEN_BIT    = 16;       // Mode bit in config
  localparam int          STAT_MATCH     = 0;        // Match bit in status
  localparam int          STAT_ADDR_LSB  = 16;       // Address in status
  localparam logic [1:0]  RESP_OKAY      = 2'h0;     // Bus answer good
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;     // Bus answer error

  // Compare settings handed to the comparator
  typedef struct packed {
    logic       ten_bit;              // One for ten-bit addressing
    logic [9:0] own_addr;             // Programmed slave address
    logic [9:0] address_ignore_bits;  // Set bit means do not care
  } cmp_cfg_s;

  // Compare result handed back
  typedef struct packed {
    logic       done;   // One-cycle pulse per compare
    logic       match;  // Address matched
    logic [9:0] addr;   // Address that was compared
  } cmp_result_s;

endpackage

// ===== sim/addr_master_model.sv
// Purpose: Far side model, a serial master sending addresses to compare
// Assumes: One request per go pulse, same clock as the block
// Notes:   Seven-bit addresses sit in bits 7:1, bit 0 is read/write
`timescale 1ns/1ns
`default_nettype none
module addr_master_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,        // Request one compare
  input  wire logic       ten,       // Ten-bit address format
  input  wire logic [9:0] addr,      // Address to send
  input  wire logic       rw,        // Direction bit, seven-bit only
  output logic [9:0]      rx_addr,   // Address to the block
  output logic            rx_valid   // One-cycle request
);
  // ************************************************************
  // Address framing
  // ************************************************************
  // Idle bus inverts every bit each cycle, so the last address comes back every other cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_addr  <= 10'h000;
      rx_valid <= 1'b0;
    end else if (go) begin
      rx_addr  <= ten ? addr : {2'h0, addr[6:0], rw};
      rx_valid <= 1'b1;
    end else begin
      rx_addr  <= ~rx_addr;
      rx_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/i2c_slave_address_mask_bench.sv
// Purpose: Self-checking bench of the slave address mask block
// Assumes: Register access over the bus tasks below
// Notes:   Expected matches are worked out from the masking rules
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_address_mask_bench;
  logic aclk = 1'b0, aresetn = 1'b0;          // Clock and reset
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;          // Bus data
  logic [3:0]  wstrb = 4'h0;                  // Byte lanes
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;            // Responses
  logic [9:0]  rx_addr, a;                    // Compare address
  logic rx_valid, addr_match, addr_done;      // Compare port
  logic go = 1'b0, ten = 1'b0, rw = 1'b0;     // Model requests
  logic [9:0]  addr = 10'h000;                // Model address
  logic [31:0] rd;                            // Read result
  logic [9:0]  cfg_own [4] = '{10'h055, 10'h055, 10'h2AA, 10'h2AA};
  logic [9:0]  cfg_msk [4] = '{10'h000, 10'h381, 10'h000, 10'h201};
  logic [9:0]  tst [8] = '{10'h055, 10'h054, 10'h057, 10'h0D5,
                           10'h2AA, 10'h0AA, 10'h2AB, 10'h3FF};
  int errors = 0, checked = 0, cyc = 0;       // Counters

  always #4 aclk = ~aclk;

  i2c_slave_address_mask i_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rx_addr(rx_addr), .rx_valid(rx_valid),
    .addr_match(addr_match), .addr_done(addr_done));

  addr_master_model i_master (.aclk(aclk), .aresetn(aresetn), .go(go),
    .ten(ten), .addr(addr), .rw(rw), .rx_addr(rx_addr),
    .rx_valid(rx_valid));

  // ************************************************************
  // Reporting
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end

  // ************************************************************
  // Bus tasks, handshakes judged at the falling edge before take
  // ************************************************************
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= ad; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask

  task automatic rd_reg(input logic [11:0] ad);
    logic ta, tr;
    @(posedge aclk);
    araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready; tr = rvalid;
      rd = rdata; resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask

  // Match expected from the masking rules
  function automatic logic exp_m(input logic t, input logic [9:0] own,
                                 input logic [9:0] m, input logic [9:0] x);
    if (t) return ((x ^ own) & ~m) == 10'h000;
    return ((x[6:0] ^ own[6:0]) & ~m[6:0]) == 7'h00;
  endfunction

  // One compare through the far side model
  task automatic cmp(input logic t, input logic [9:0] x, input logic d);
    int n;
    @(posedge aclk);
    go <= 1'b1; ten <= t; addr <= x; rw <= d;
    @(posedge aclk);
    go <= 1'b0;
    n = 0;
    while (addr_done !== 1'b1 && n < 6) begin
      @(negedge aclk);
      n++;
    end
    chk({31'h0, addr_done}, 32'h1);
    chk(n, 32'h2);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(addr_mask_pkg::OFS_MASK);
    chk(rd, 32'h0);
    rd_reg(addr_mask_pkg::OFS_CONFIG);
    chk(rd, 32'h0);
    wr(addr_mask_pkg::OFS_MASK, 32'hFFFFFFFF);
    chk({30'h0, resp}, {30'h0, addr_mask_pkg::RESP_OKAY});
    rd_reg(addr_mask_pkg::OFS_MASK);
    chk(rd, 32'h000003FF);
    wr(12'h00C, 32'h1);
    chk({30'h0, resp}, {30'h0, addr_mask_pkg::RESP_SLVERR});
    rd_reg(12'h00C);
    chk({30'h0, resp}, {30'h0, addr_mask_pkg::RESP_SLVERR});
    for (int c = 0; c < 4; c++) begin
      wr(addr_mask_pkg::OFS_CONFIG, {15'h0, c > 1, 6'h0, cfg_own[c]});
      rd_reg(addr_mask_pkg::OFS_CONFIG);
      chk(rd, {15'h0, c > 1, 6'h0, cfg_own[c]});
      wr(addr_mask_pkg::OFS_MASK, {22'h0, cfg_msk[c]});
      rd_reg(addr_mask_pkg::OFS_MASK);
      chk(rd, {22'h0, cfg_msk[c]});
      for (int i = 0; i < 8; i++) begin
        a = tst[i];
        cmp(c > 1, a, i[0]);
        chk({31'h0, addr_match},
            {31'h0, exp_m(c > 1, cfg_own[c], cfg_msk[c], a)});
        rd_reg(addr_mask_pkg::OFS_STATUS);
        chk({31'h0, rd[addr_mask_pkg::STAT_MATCH]},
            {31'h0, exp_m(c > 1, cfg_own[c], cfg_msk[c], a)});
        chk({22'h0, rd[addr_mask_pkg::STAT_ADDR_LSB+:10]},
            {22'h0, (c > 1) ? a : {2'h0, a[6:0], i[0]}});
      end
    end
    test_done();
  end
endmodule
`default_nettype wire
